// >>> epp_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
// =========================================================
// behavioural byte-wide memory on the programmer's pins
module epp_dev_model
    import epp_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE  = 8'h5C, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h3E  // arbitrary value
) (
    // clock
    input  wire logic              clock_i,
    // pins from the host and resolved data wire
    input  wire epp_pins_t         pins_i,
    input  wire logic [DATA_W-1:0] bus_i,
    // device data outputs
    output logic      [DATA_W-1:0] q_o,
    output logic                   q_oe_n_o,
    // pulse and fault counts
    output int                     pulses_o,
    output int                     errs_o
);
    logic [DATA_W-1:0] mem [0:15];
    logic [DATA_W-1:0] pdata;
    int                low_cnt;
    logic              hi_sup;
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 8'hFF;
        end
        pulses_o = 0;
        errs_o = 0;
        low_cnt = 0;
    end
    assign hi_sup = pins_i.prog_supply_hi && pins_i.core_supply_hi;
    always @(posedge clock_i) begin
        if (hi_sup && !pins_i.chip_select_n) begin
            low_cnt <= low_cnt + 1;
            pdata <= bus_i;
            if (!pins_i.output_gate_n) errs_o <= errs_o + 1;
        end else if (low_cnt != 0) begin
            mem[pins_i.address_inputs[3:0]] <=
                mem[pins_i.address_inputs[3:0]] & pdata;
            pulses_o <= pulses_o + 1;
            low_cnt <= 0;
            if (low_cnt < T_PMIN_CYC || low_cnt > T_PMAX_CYC) begin
                errs_o <= errs_o + 1;
            end
        end
        if (pins_i.sig_hv_en && ({pins_i.address_inputs[18:10],
            pins_i.address_inputs[8:1]} != 17'h0)) begin
            errs_o <= errs_o + 1; // upper lines held low
        end
    end
    // drive when gated low: select high under both supplies, select low without program supply
    always_comb begin
        q_oe_n_o = 1'b1;
        q_o = mem[pins_i.address_inputs[3:0]];
        if (hi_sup && pins_i.chip_select_n && !pins_i.output_gate_n) begin
            q_oe_n_o = 1'b0;
        end else if (!pins_i.prog_supply_hi && !pins_i.chip_select_n &&
                     !pins_i.output_gate_n) begin
            q_oe_n_o = 1'b0;
            if (pins_i.sig_hv_en) begin
                q_o = pins_i.address_inputs[0] ? DEVICE_CODE : MAKER_CODE;
            end
        end
    end
endmodule : epp_dev_model
`default_nettype wire

// >>> epp_pkg.sv
package epp_pkg;
    // =========================================================
    // widths
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    // =========================================================
    // timing at 200 MHz
    localparam int CLK_PS         = 5000;
    localparam int T_SETUP_US     = 2;
    localparam int T_PULSE_US     = 100;
    localparam int T_PULSE_MIN_US = 95;
    localparam int T_PULSE_MAX_US = 105;
    localparam int T_SETUP_CYC    = (T_SETUP_US * 1000000 + CLK_PS - 1)
                                    / CLK_PS;
    localparam int T_PULSE_CYC    = (T_PULSE_US * 1000000) / CLK_PS;
    localparam int T_PMIN_CYC     = (T_PULSE_MIN_US * 1000000 + CLK_PS - 1)
                                    / CLK_PS;
    localparam int T_PMAX_CYC     = (T_PULSE_MAX_US * 1000000) / CLK_PS;
    localparam int CNT_W          = 16;
    localparam logic [7:0] MAX_TRIES = 8'h19;
    localparam logic [7:0] ERASED    = 8'hFF;
    // =========================================================
    // commands and pin bundle
    typedef enum logic [1:0] {
        EPP_CMD_PROG = 2'h0,
        EPP_CMD_READ = 2'h1,
        EPP_CMD_SIG  = 2'h2
    } epp_cmd_t;
    typedef struct packed {
        logic              chip_select_n;
        logic              output_gate_n;
        logic              prog_supply_hi;
        logic              core_supply_hi;
        logic              sig_hv_en;
        logic [ADDR_W-1:0] address_inputs;
    } epp_pins_t;
endpackage : epp_pkg

// >>> epp_prog_host.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - program mode needs high program supply and chip select low
// - whole byte and address driven on pins during a pulse
// - repeat 100 us pulses each followed by verify, no overprogram
// - only chip select is per device; other pins shared
// - verify: gate low, select high, both supplies raised
// - signature mode: high voltage on address pin, supplies normal
// - other address lines held low in signature mode
// - device drives data with gate low: select low to read, select high to verify
// - program pulse lasts 95 to 105 us
module epp_prog_host
    import epp_pkg::*;
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              sys_rst_i,
    input  wire logic              ce_i,
    // command port
    input  wire logic              cmd_valid_i,
    input  wire epp_cmd_t          cmd_i,
    input  wire logic [ADDR_W-1:0] cmd_addr_i,
    input  wire logic [DATA_W-1:0] cmd_data_i,
    output logic                   cmd_ready_o,
    output logic                   done_o,
    output logic                   fail_o,
    output logic      [DATA_W-1:0] rdata_o,
    // device pins
    output epp_pins_t              pins_o,
    output logic      [DATA_W-1:0] dq_o,
    output logic                   dq_oe_n_o,
    input  wire logic [DATA_W-1:0] dq_i
);
    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_SETUP = 7'h02,
        S_PULSE = 7'h04,
        S_HOLD  = 7'h08,
        S_VFY   = 7'h10,
        S_READ  = 7'h20,
        S_DONE  = 7'h40
    } epp_state_t;

    epp_state_t        state;
    epp_cmd_t          cmd;
    logic [CNT_W-1:0]  cnt;
    logic [7:0]        tries;
    logic [DATA_W-1:0] want;
    logic [DATA_W-1:0] dq_sync;
    logic              cnt_zero;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0]  low_run;

    // checks share one clock and one reset
    default clocking dc_main @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    assign cnt_zero = (cnt == '0);

    // =========================================================
    // pin input synchroniser
    epp_sync u_sync (
        .clock_i (clock_i),
        .ce_i    (ce_i),
        .d_i     (dq_i),
        .q_o     (dq_sync)
    );

    // =========================================================
    // sequencer
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state <= S_IDLE;
            cmd   <= EPP_CMD_READ;
            cnt   <= '0;
            tries <= 8'h00;
            want  <= 8'h00;
            addr  <= '0;
        end else if (ce_i) begin
            if (!cnt_zero) begin
                cnt <= cnt - 1'b1;
            end
            unique case (state)
                S_IDLE: begin
                    if (cmd_valid_i) begin
                        cmd   <= cmd_i;
                        want  <= cmd_data_i;
                        addr  <= cmd_addr_i; // held for the whole command
                        tries <= 8'h00;
                        cnt   <= CNT_W'(T_SETUP_CYC);
                        state <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (cnt_zero) begin
                        if (cmd != EPP_CMD_PROG) begin
                            state <= S_READ;
                            cnt   <= CNT_W'(T_SETUP_CYC);
                        end else if (want == ERASED) begin
                            state <= S_VFY;
                            cnt   <= CNT_W'(T_SETUP_CYC);
                        end else begin
                            state <= S_PULSE;
                            cnt   <= CNT_W'(T_PULSE_CYC - 1);
                        end
                    end
                end
                S_PULSE: begin
                    if (cnt_zero) begin
                        tries <= tries + 8'h01;
                        state <= S_HOLD;
                        cnt   <= CNT_W'(T_SETUP_CYC);
                    end
                end
                S_HOLD: begin
                    if (cnt_zero) begin
                        state <= S_VFY;
                        cnt   <= CNT_W'(T_SETUP_CYC);
                    end
                end
                // verify then pulse again or finish
                S_VFY: begin
                    if (cnt_zero) begin
                        if (dq_sync == want || tries >= MAX_TRIES
                            || (~dq_sync & want) != 8'h00) begin
                            state <= S_DONE;
                        end else begin
                            // data settles again before the next pulse
                            state <= S_SETUP;
                            cnt   <= CNT_W'(T_SETUP_CYC);
                        end
                    end
                end
                S_READ: begin
                    if (cnt_zero) begin
                        state <= S_DONE;
                    end
                end
                S_DONE: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // =========================================================
    // pin drive, all registered
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pins_o    <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, '0};
            dq_o      <= 8'h00;
            dq_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            // select high unless pulsing or reading
            pins_o.chip_select_n <= 1'b1;
            pins_o.output_gate_n <= 1'b1;
            dq_oe_n_o            <= 1'b1;
            if (state != S_IDLE && state != S_DONE) begin
                pins_o.address_inputs <= (cmd == EPP_CMD_SIG)
                    ? {{(ADDR_W-1){1'b0}}, addr[0]}
                    : addr;
                pins_o.prog_supply_hi <= (cmd == EPP_CMD_PROG);
                pins_o.core_supply_hi <= (cmd == EPP_CMD_PROG);
                pins_o.sig_hv_en      <= (cmd == EPP_CMD_SIG);
            end else begin
                pins_o.prog_supply_hi <= 1'b0;
                pins_o.core_supply_hi <= 1'b0;
                pins_o.sig_hv_en      <= 1'b0;
            end
            if (cmd == EPP_CMD_PROG && (state == S_SETUP ||
                state == S_PULSE || state == S_HOLD)) begin
                dq_o      <= want;
                dq_oe_n_o <= 1'b0;
            end
            // select is the only per-device pin
            // low select pulse, gate stays high
            if (state == S_PULSE) begin
                pins_o.chip_select_n <= 1'b0;
            end
            // verify with select high and gate low
            if (state == S_VFY) begin
                pins_o.output_gate_n <= 1'b0;
            end
            if (state == S_READ) begin
                pins_o.chip_select_n <= 1'b0;
                pins_o.output_gate_n <= 1'b0;
            end
        end
    end

    // =========================================================
    // answer
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cmd_ready_o <= 1'b0;
            done_o      <= 1'b0;
            fail_o      <= 1'b0;
            rdata_o     <= 8'h00;
        end else if (ce_i) begin
            cmd_ready_o <= (state == S_IDLE) && !cmd_valid_i;
            done_o      <= 1'b0;
            if ((state == S_VFY || state == S_READ) && cnt_zero) begin
                rdata_o <= dq_sync;
            end
            // fail when a program command ends with a read-back mismatch
            if (state == S_DONE) begin
                done_o <= 1'b1;
                fail_o <= (cmd == EPP_CMD_PROG) && (rdata_o != want);
            end
        end
    end

    // =========================================================
    // checks
    sequence s_pulse_rise;
        ce_i && state == S_SETUP && cnt_zero && cmd == EPP_CMD_PROG
            && want != ERASED;
    endsequence

    // low time of the select pin
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            low_run <= '0;
        end else if (ce_i) begin
            low_run <= pins_o.chip_select_n ? '0 : low_run + 1'b1;
        end
    end

    a_pulse_width: assert property (
        $fell(pins_o.chip_select_n) && pins_o.prog_supply_hi |->
        !pins_o.chip_select_n [*8]
    ) else $error("program pulse too short");
    a_pulse_len: assert property (
        $rose(pins_o.chip_select_n) && pins_o.prog_supply_hi |->
        low_run >= CNT_W'(T_PMIN_CYC) && low_run <= CNT_W'(T_PMAX_CYC)
    ) else $error("program pulse length out of range");
    a_gate_high: assert property (
        !pins_o.chip_select_n && pins_o.prog_supply_hi |->
        pins_o.output_gate_n && !dq_oe_n_o
    ) else $error("gate low during program pulse");
    a_pulse_supply: assert property (
        !pins_o.chip_select_n && !dq_oe_n_o |-> pins_o.prog_supply_hi
    ) else $error("pulse without program supply");
    a_verify_pins: assert property (
        !pins_o.output_gate_n && pins_o.prog_supply_hi |->
        pins_o.chip_select_n && pins_o.core_supply_hi && dq_oe_n_o
    ) else $error("verify pin levels wrong");
    a_sig_addr: assert property (
        pins_o.sig_hv_en |-> pins_o.address_inputs[ADDR_W-1:1] == '0
    ) else $error("address high in signature mode");
    a_sig_supply: assert property (
        pins_o.sig_hv_en |-> !pins_o.prog_supply_hi
    ) else $error("program supply high in signature mode");
    a_pulse_start: assert property (
        s_pulse_rise |=> ##1 !pins_o.chip_select_n
    ) else $error("pulse did not start");
    a_no_contend: assert property (
        !pins_o.output_gate_n |-> dq_oe_n_o
    ) else $error("host drives while device reads out");
endmodule : epp_prog_host
`default_nettype wire

// >>> epp_prog_host_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module epp_prog_host_tb_top
    import epp_pkg::*;
;
    logic clock_i = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0;
    logic ce = 1'b1;
    epp_cmd_t cmd = EPP_CMD_READ;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_data = '0, rdata, host_dq, dev_q, bus;
    logic [DATA_W-1:0] last_bus = '0;
    logic ready, done, fail, dq_oe_n, dev_oe_n;
    epp_pins_t pins;
    int pulses, errs, bad_count = 0, num_checks = 0;
    always #2.5 clock_i = ~clock_i;
    // =========================================================
    // wire resolution, undriven wire toggles every cycle
    assign bus = !dev_oe_n ? dev_q : (!dq_oe_n ? host_dq : ~last_bus);
    always @(posedge clock_i) last_bus <= bus;
    epp_prog_host u_epp_prog_host (.clock_i(clock_i), .sys_rst_i(sys_rst),
        .ce_i(ce), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
        .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .cmd_ready_o(ready),
        .done_o(done), .fail_o(fail), .rdata_o(rdata), .pins_o(pins),
        .dq_o(host_dq), .dq_oe_n_o(dq_oe_n), .dq_i(bus));
    epp_dev_model u_epp_dev_model (.clock_i(clock_i), .pins_i(pins),
        .bus_i(bus), .q_o(dev_q), .q_oe_n_o(dev_oe_n), .pulses_o(pulses),
        .errs_o(errs));
    // =========================================================
    // compare and finish
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    // one command, waits for the done pulse
    task automatic run_cmd(input epp_cmd_t c, input logic [18:0] a,
                           input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        cmd_valid <= 1'b1;
        cmd <= c;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge clock_i);
        cmd_valid <= 1'b0;
        do begin
            @(posedge clock_i);
            #1;
            n++;
        end while (done !== 1'b1 && n < 25000);
        check({7'h0, done}, 8'h01);
    endtask : run_cmd
    // =========================================================
    // scenarios
    task automatic t_idle;
        check({3'h0, pins[ADDR_W+4:ADDR_W]}, 8'h18);
        check(pins.address_inputs[7:0], 8'h00);
        check({6'h0, dq_oe_n, ready}, 8'h03);
        $display("test idle done");
    endtask : t_idle
    // enable low: a request must not be taken
    task automatic t_freeze;
        @(posedge clock_i);
        ce <= 1'b0;
        cmd_valid <= 1'b1;
        cmd <= EPP_CMD_READ;
        repeat (4) @(posedge clock_i);
        cmd_valid <= 1'b0;
        @(posedge clock_i);
        ce <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        check({7'h0, ready}, 8'h01);
        check({3'h0, pins[ADDR_W+4:ADDR_W]}, 8'h18);
        $display("test freeze done");
    endtask : t_freeze
    task automatic t_sig;
        for (int i = 0; i < 2; i++) begin
            run_cmd(EPP_CMD_SIG, 19'(i), 8'h00);
            check(rdata, i ? 8'h3E : 8'h5C);
        end
        $display("test signature done");
    endtask : t_sig
    task automatic t_prog;
        run_cmd(EPP_CMD_PROG, 19'h5, 8'hA5);
        check({7'h0, fail}, 8'h00);
        check(8'(pulses), 8'h01);
        run_cmd(EPP_CMD_READ, 19'h5, 8'h00);
        check(rdata, 8'hA5);
        $display("test program done");
    endtask : t_prog
    task automatic t_erased;
        run_cmd(EPP_CMD_PROG, 19'h6, 8'hFF);
        check({7'h0, fail}, 8'h00);
        check(8'(pulses), 8'h01);
        run_cmd(EPP_CMD_READ, 19'h6, 8'h00);
        check(rdata, 8'hFF);
        $display("test erased done");
    endtask : t_erased
    task automatic t_refuse;
        run_cmd(EPP_CMD_PROG, 19'h5, 8'h5A);
        // one pulse lands before the clash shows: only zeros stick
        check({7'h0, fail}, 8'h01);
        check(8'(pulses), 8'h02);
        run_cmd(EPP_CMD_READ, 19'h5, 8'h00);
        check(rdata, 8'hA5 & 8'h5A);
        check({7'h0, fail}, 8'h00);
        check(8'(errs), 8'h00);
        $display("test refuse done");
    endtask : t_refuse
    // =========================================================
    // main sequence and watchdog
    initial begin
        repeat (16) @(posedge clock_i);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
        t_idle();
        t_freeze();
        t_sig();
        t_prog();
        t_erased();
        t_refuse();
        close_out();
    end
    initial begin
        #(5 * 80000);
        bad_count++;
        close_out();
    end
endmodule : epp_prog_host_tb_top
`default_nettype wire

// >>> epp_sync.sv
`timescale 1ns/10ps
`default_nettype none
// three-stage synchroniser, change taken when stages two and three agree
module epp_sync
    import epp_pkg::*;
(
    // clock
    input  wire logic              clock_i,
    input  wire logic              ce_i,
    // data
    input  wire logic [DATA_W-1:0] d_i,
    output logic      [DATA_W-1:0] q_o
);
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic [DATA_W-1:0] s3;
    // =========================================================
    // stages
    always_ff @(posedge clock_i) begin
        if (ce_i) begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end
    // accept once two stages agree
    always_ff @(posedge clock_i) begin
        if (ce_i && s2 == s3) begin
            q_o <= s3;
        end
    end
endmodule : epp_sync
`default_nettype wire
